// ===== hw/ibts_pkg.sv
// package of constants for the in-band tone signalling control block
// Function
// - single tones programmable anywhere from 288 Hz to 3000 Hz
// - default selcall table at reset; host may overwrite entries through programming port
// - dtmf and selcall detectors may run together in receive mode
// - transmit voice path disabled while either tone generator runs
// - transmit tone word: selcall code bits 14..11, dtmf code bits 3..0
// - tone output level comes from the audio control level sub-field
// - twist option drops lower dtmf component 2 dB below upper
// - single-tone option outputs only the designated dtmf component
// - status bit 13 pulses when valid in-band tone starts, stops or changes
// - candidate tone matched against table ascending; first match reported
// - tone status cleared to zero when a valid tone ends
// - selcall detect sets bit 15 and places code in bits 14..11
// - selcall code 14 is the repeat tone, reported like any other
// - status bit 12 pulses when a valid dtmf tone starts or stops
// - dtmf receive sets bit 10 and places code in bits 14..11
// - dtmf code to key and row/column frequency map as tabulated
// - default selcall table 1981,1124,...,2110,1055 Hz for codes 0..15
`default_nettype none
package ibts_pkg;
  localparam int FW = 12;                       // frequency word width, Hz
  localparam int NTONE = 16;
  localparam logic [11:0] FREQ_MIN = 12'h0_120;  // 288 Hz
  localparam logic [11:0] FREQ_MAX = 12'h0_BB8;  // 3000 Hz
  localparam logic [11:0] MATCH_TOL = 12'h0_00A; // candidate match window, Hz
  localparam int TX_SEL_HI = 14;
  localparam int TX_SEL_LO = 11;
  localparam int TX_SEL_EN = 15;
  localparam int TX_DTMF_EN = 7;
  localparam int TX_TWIST = 5;
  localparam int TX_SINGLE = 4;
  localparam int ST_SEL_BIT = 15;
  localparam int ST_DTMF_BIT = 10;
  localparam int STS_INB_BIT = 13;
  localparam int STS_DTMF_BIT = 12;
  localparam logic [3:0] REPEAT_CODE = 4'hE;
  localparam logic [7:0] TWIST_DB_X10 = 8'h0_14;  // 2.0 dB in tenths
  localparam logic [15:0] ST_CLEAR = 16'h0_000;
  // default selcall table, codes 0..15
  localparam logic [11:0] DEF_TABLE [NTONE] = '{
    12'h0_7BD, 12'h0_464, 12'h0_4AD, 12'h0_4FB, 12'h0_54E, 12'h0_5A6, 12'h0_604, 12'h0_668,
    12'h0_6D3, 12'h0_744, 12'h0_960, 12'h0_3A2, 12'h0_8C7, 12'h0_3DF, 12'h0_83E, 12'h0_41F};
  // dtmf rows and columns
  localparam logic [11:0] DTMF_ROW [4] = '{12'h0_2B9, 12'h0_302, 12'h0_354, 12'h0_3AD};
  localparam logic [11:0] DTMF_COL [4] = '{12'h0_4B9, 12'h0_538, 12'h0_5C5, 12'h0_661};
endpackage : ibts_pkg
`default_nettype wire

// ===== hw/ibts_dtmf_map.sv
// dtmf code to row/column frequency lookup
`timescale 1ns/100ps
`default_nettype none
module ibts_dtmf_map (
  input  wire logic [3:0]  code_in,
  output logic      [11:0] low_hz_out,
  output logic      [11:0] high_hz_out,
  output logic             low_marked_out
);
  logic [1:0] row;
  logic [1:0] col;
  // key layout: A=0, B=*, C=#, D..F=A..C, 0=D
  always_comb begin
    row = 2'd0;
    col = 2'd0;
    case (code_in)
      4'h1, 4'h2, 4'h3: begin row = 2'd0; col = 2'(code_in - 4'h1); end
      4'h4, 4'h5, 4'h6: begin row = 2'd1; col = 2'(code_in - 4'h4); end
      4'h7, 4'h8, 4'h9: begin row = 2'd2; col = 2'(code_in - 4'h7); end
      4'hA:             begin row = 2'd3; col = 2'd1; end
      4'hB:             begin row = 2'd3; col = 2'd0; end
      4'hC:             begin row = 2'd3; col = 2'd2; end
      4'hD, 4'hE, 4'hF: begin row = 2'(code_in - 4'hD); col = 2'd3; end
      default:          begin row = 2'd3; col = 2'd3; end
    endcase
  end
  assign low_hz_out  = ibts_pkg::DTMF_ROW[row];
  assign high_hz_out = ibts_pkg::DTMF_COL[col];
  // single-tone component: low for codes 1..7 and 0, high otherwise
  assign low_marked_out = (code_in <= 4'h7);
endmodule : ibts_dtmf_map
`default_nettype wire

// ===== hw/ibts_top.sv
// in-band tone signalling control: table, tx tone select, rx status and events
`timescale 1ns/100ps
`default_nettype none
module ibts_top (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // table programming port
  input  wire logic        prog_we_in,
  input  wire logic [3:0]  prog_idx_in,
  input  wire logic [11:0] prog_hz_in,
  output logic             prog_err_out,
  // transmit control
  input  wire logic [15:0] tx_tone_word_in,
  input  wire logic        tx_tone_we_in,
  input  wire logic [3:0]  tone_level_in,
  input  wire logic        tx_voice_req_in,
  output logic             tx_voice_en_out,
  output logic             tx_tone_on_out,
  output logic [11:0]      tx_hz_a_out,
  output logic [11:0]      tx_hz_b_out,
  output logic [3:0]       tx_level_a_out,
  output logic [3:0]       tx_level_b_out,
  output logic [7:0]       tx_atten_a_out,
  // receive detectors
  input  wire logic        rx_sel_en_in,
  input  wire logic        rx_dtmf_en_in,
  input  wire logic        cand_valid_in,
  input  wire logic [11:0] cand_hz_in,
  input  wire logic        dtmf_valid_in,
  input  wire logic [3:0]  dtmf_code_in,
  // status to host
  output logic [15:0]      tone_status_out,
  output logic             inb_event_out,
  output logic             dtmf_event_out,
  output logic             repeat_seen_out
);
  // ==========================================================
  // tone table
  logic [11:0] table_q [ibts_pkg::NTONE];
  logic        prog_err_q;
  logic        prog_ok;

  assign prog_ok = (prog_hz_in >= ibts_pkg::FREQ_MIN) && (prog_hz_in <= ibts_pkg::FREQ_MAX);

  // reset loads the default set; host writes are accepted only in range
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      table_q <= ibts_pkg::DEF_TABLE;
    end else if (prog_we_in && prog_ok) begin
      table_q[prog_idx_in] <= prog_hz_in; // one location per code
    end
  end

  // out-of-range write flagged so firmware can see it was dropped
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      prog_err_q <= 1'b0;
    end else if (prog_we_in) begin
      prog_err_q <= !prog_ok;
    end
  end
  assign prog_err_out = prog_err_q;

  // ==========================================================
  // transmit tone selection
  logic [15:0] tx_word_q;
  logic        sel_on;
  logic        dtmf_on;
  logic [11:0] d_low;
  logic [11:0] d_high;
  logic        d_low_mark;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_word_q <= 16'h0_000;
    end else if (tx_tone_we_in) begin
      tx_word_q <= tx_tone_word_in; // selcall 14..11, dtmf 3..0
    end
  end

  assign sel_on  = tx_word_q[ibts_pkg::TX_SEL_EN];
  assign dtmf_on = tx_word_q[ibts_pkg::TX_DTMF_EN] && !sel_on;

  ibts_dtmf_map u_map (
    .code_in        (tx_word_q[3:0]),
    .low_hz_out     (d_low),
    .high_hz_out    (d_high),
    .low_marked_out (d_low_mark)
  );

  logic [11:0] hz_a_d;
  logic [11:0] hz_b_d;
  logic [7:0]  att_d;
  // choose generator frequencies; repeat code 14 sent as any other code
  always_comb begin
    hz_a_d = 12'h0_000;
    hz_b_d = 12'h0_000;
    att_d  = 8'h0_00;
    if (sel_on) begin
      hz_a_d = table_q[tx_word_q[ibts_pkg::TX_SEL_HI:ibts_pkg::TX_SEL_LO]];
    end else if (dtmf_on) begin
      if (tx_word_q[ibts_pkg::TX_SINGLE]) begin
        hz_a_d = d_low_mark ? d_low : d_high; // designated component only
      end else begin
        hz_a_d = d_low;
        hz_b_d = d_high;
        if (tx_word_q[ibts_pkg::TX_TWIST]) begin
          att_d = ibts_pkg::TWIST_DB_X10; // low tone 2 dB down
        end
      end
    end
  end

  // generator controls registered for clean data outputs
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_hz_a_out    <= 12'h0_000;
      tx_hz_b_out    <= 12'h0_000;
      tx_atten_a_out <= 8'h0_00;
      tx_level_a_out <= 4'h0;
      tx_level_b_out <= 4'h0;
      tx_tone_on_out <= 1'b0;
    end else begin
      tx_hz_a_out    <= hz_a_d;
      tx_hz_b_out    <= hz_b_d;
      tx_atten_a_out <= att_d;
      tx_level_a_out <= (hz_a_d != 12'h0_000) ? tone_level_in : 4'h0;
      tx_level_b_out <= (hz_b_d != 12'h0_000) ? tone_level_in : 4'h0;
      tx_tone_on_out <= sel_on || dtmf_on;
    end
  end

  // voice path muted while any generator runs, so nothing else shares the band
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_voice_en_out <= 1'b0;
    end else begin
      tx_voice_en_out <= tx_voice_req_in && !(sel_on || dtmf_on);
    end
  end

  // ==========================================================
  // receive: table scan for candidate tone
  logic       hit;
  logic [3:0] hit_idx;
  logic [11:0] diff;
  // descending loop so the lowest matching index wins
  always_comb begin
    hit     = 1'b0;
    hit_idx = 4'h0;
    diff    = 12'h0_000;
    for (int i = ibts_pkg::NTONE - 1; i >= 0; i--) begin
      diff = (cand_hz_in > table_q[i]) ? (cand_hz_in - table_q[i]) : (table_q[i] - cand_hz_in);
      if (diff <= ibts_pkg::MATCH_TOL) begin
        hit     = 1'b1;
        hit_idx = 4'(i);
      end
    end
  end

  logic       sel_valid;
  logic       dtm_valid;
  // both detectors may be enabled together; selcall wins and dtmf is not reported while selcall is valid
  assign sel_valid = rx_sel_en_in && cand_valid_in && hit;
  assign dtm_valid = rx_dtmf_en_in && dtmf_valid_in;

  // ==========================================================
  // tone status register and change events
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic        inb_ev_q;
  logic        dtmf_ev_q;

  always_comb begin
    status_d = ibts_pkg::ST_CLEAR; // ended tone clears everything
    if (sel_valid) begin
      status_d[ibts_pkg::ST_SEL_BIT] = 1'b1;
      status_d[ibts_pkg::TX_SEL_HI:ibts_pkg::TX_SEL_LO] = hit_idx;
    end else if (dtm_valid) begin
      status_d[ibts_pkg::ST_DTMF_BIT] = 1'b1;
      status_d[ibts_pkg::TX_SEL_HI:ibts_pkg::TX_SEL_LO] = dtmf_code_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      status_q <= ibts_pkg::ST_CLEAR;
    end else begin
      status_q <= status_d;
    end
  end
  assign tone_status_out = status_q;

  // in-band event on on/off/change of selcall tone
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      inb_ev_q <= 1'b0;
    end else begin
      inb_ev_q <= (status_d[ibts_pkg::ST_SEL_BIT] != status_q[ibts_pkg::ST_SEL_BIT]) ||
                  (status_d[ibts_pkg::ST_SEL_BIT] &&
                   status_d[ibts_pkg::TX_SEL_HI:ibts_pkg::TX_SEL_LO] !=
                   status_q[ibts_pkg::TX_SEL_HI:ibts_pkg::TX_SEL_LO]);
    end
  end

  // dtmf event only on start and stop
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      dtmf_ev_q <= 1'b0;
    end else begin
      dtmf_ev_q <= status_d[ibts_pkg::ST_DTMF_BIT] != status_q[ibts_pkg::ST_DTMF_BIT];
    end
  end
  assign inb_event_out  = inb_ev_q;
  assign dtmf_event_out = dtmf_ev_q;

  // repeat marker is a hint only; host decodes the protocol itself
  assign repeat_seen_out = status_q[ibts_pkg::ST_SEL_BIT] &&
    (status_q[ibts_pkg::TX_SEL_HI:ibts_pkg::TX_SEL_LO] == ibts_pkg::REPEAT_CODE);
endmodule : ibts_top
`default_nettype wire

// ===== tb/ibts_props.sv
// assertion checker for the in-band tone signalling block
`timescale 1ns/100ps
`default_nettype none
// ==========
// checker
module ibts_props (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        tx_voice_req_in,
  input wire logic        tx_voice_en_out,
  input wire logic        tx_tone_on_out,
  input wire logic [7:0]  tx_atten_a_out,
  input wire logic        cand_valid_in,
  input wire logic        dtmf_valid_in,
  input wire logic [15:0] tone_status_out,
  input wire logic        inb_event_out,
  input wire logic        dtmf_event_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // tone and voice never share the band
  voice_mute_a: assert property (tx_tone_on_out |-> !tx_voice_en_out)
    else $error("voice open during tone");
  voice_pass_a: assert property ((tx_voice_req_in && !tx_tone_on_out) [*3] |-> tx_voice_en_out)
    else $error("voice path stuck off");
  sel_wins_a: assert property (tone_status_out[15] |-> !tone_status_out[10])
    else $error("selcall and dtmf flags both set");
  // events tied to status changes
  dtmf_evt_a: assert property ($changed(tone_status_out[10]) |-> dtmf_event_out)
    else $error("dtmf event missing");
  dtmf_cause_a: assert property (dtmf_event_out |-> $changed(tone_status_out[10]))
    else $error("dtmf event without change");
  inb_cause_a: assert property (inb_event_out |-> $changed(tone_status_out))
    else $error("tone event without change");
  inb_evt_a: assert property ($changed(tone_status_out[15:11]) && (tone_status_out[15]
    || $past(tone_status_out[15])) |-> inb_event_out)
    else $error("tone event missing");
  quiet_clear_a: assert property (!cand_valid_in && !dtmf_valid_in |=> tone_status_out == 0)
    else $error("status not cleared");
  twist_level_a: assert property (tx_atten_a_out != 8'h00
    |-> tx_atten_a_out == ibts_pkg::TWIST_DB_X10)
    else $error("twist attenuation wrong");
  c_inb: cover property (inb_event_out);
  c_dtmf: cover property (dtmf_event_out);
  c_twist: cover property (tx_tone_on_out && tx_atten_a_out != 8'h00);
endmodule : ibts_props
bind ibts_top ibts_props u_props (.clk_in(clk_in), .nrst_in(nrst_in),
  .tx_voice_req_in(tx_voice_req_in), .tx_voice_en_out(tx_voice_en_out),
  .tx_tone_on_out(tx_tone_on_out), .tx_atten_a_out(tx_atten_a_out),
  .cand_valid_in(cand_valid_in), .dtmf_valid_in(dtmf_valid_in),
  .tone_status_out(tone_status_out), .inb_event_out(inb_event_out),
  .dtmf_event_out(dtmf_event_out));
`default_nettype wire

// ===== tb/ibts_host.sv
// host model: programs the tone table and builds selcall digit strings
`timescale 1ns/100ps
`default_nettype none
// ==========
// host
module ibts_host (
  input  wire logic        clk_in,
  output logic             prog_we_out = 1'b0,
  output logic [3:0]       prog_idx_out = 4'h0,
  output logic [11:0]      prog_hz_out = 12'h000
);
  // one table write held over one edge; released lines show the inverse
  task automatic write_entry(input logic [3:0] idx, input logic [11:0] hz);
    prog_we_out = 1'b1;
    prog_idx_out = idx;
    prog_hz_out = hz;
    @(posedge clk_in);
    #1;
    prog_we_out = 1'b0;
    prog_idx_out = ~idx;
    prog_hz_out = ~hz;
    // one idle edge so back-to-back writes never retoggle the strobe in one step
    @(posedge clk_in);
    #1;
  endtask : write_entry
  // device never adds repeats, so a doubled digit is swapped here
  function automatic logic [3:0] next_digit(input logic [3:0] dg, input logic [3:0] prv);
    return (dg == prv) ? ibts_pkg::REPEAT_CODE : dg;
  endfunction : next_digit
endmodule : ibts_host
`default_nettype wire

// ===== tb/ibts_top_tb.sv
// self-checking bench for the in-band tone signalling block
`timescale 1ns/100ps
`default_nettype none
module ibts_top_tb;
  // ==========
  // signals and reference tables
  logic        clk_in = 1'b0, nrst_in = 1'b0, tx_we = 1'b0, voice_req = 1'b0;
  logic        sel_en = 1'b0, dtmf_en = 1'b0, cand_v = 1'b0, dtmf_v = 1'b0;
  logic [3:0]  level = 4'h0, dcode = 4'h0, prev = 4'hF, d, lvl_a, lvl_b, prog_idx;
  logic [11:0] cand_hz = 12'h000, hz_a, hz_b, prog_hz, e_a, e_b;
  logic [15:0] tx_word = 16'h0000, status;
  logic [7:0]  atten;
  logic        prog_we, prog_err, voice_en, tone_on, inb_ev, dtmf_ev, rep_seen;
  int          bad_count = 0, check_count = 0, n_inb = 0, n_dtmf = 0, cyc = 0, n0, m;
  int          tbl [16];
  int          row_of [16] = '{3, 0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 3, 0, 1, 2};
  int          col_of [16] = '{3, 0, 1, 2, 0, 1, 2, 0, 1, 2, 1, 0, 2, 3, 3, 3};
  int          hz_l [4] = '{1124, 3000, 288, 1640};
  int          cd_l [4] = '{1, 5, 6, 7};
  ibts_top DUT (
    .clk_in(clk_in), .nrst_in(nrst_in), .prog_we_in(prog_we), .prog_idx_in(prog_idx),
    .prog_hz_in(prog_hz), .prog_err_out(prog_err), .tx_tone_word_in(tx_word),
    .tx_tone_we_in(tx_we), .tone_level_in(level), .tx_voice_req_in(voice_req),
    .tx_voice_en_out(voice_en), .tx_tone_on_out(tone_on), .tx_hz_a_out(hz_a),
    .tx_hz_b_out(hz_b), .tx_level_a_out(lvl_a), .tx_level_b_out(lvl_b),
    .tx_atten_a_out(atten), .rx_sel_en_in(sel_en), .rx_dtmf_en_in(dtmf_en),
    .cand_valid_in(cand_v), .cand_hz_in(cand_hz), .dtmf_valid_in(dtmf_v),
    .dtmf_code_in(dcode), .tone_status_out(status), .inb_event_out(inb_ev),
    .dtmf_event_out(dtmf_ev), .repeat_seen_out(rep_seen));
  ibts_host host (.clk_in(clk_in), .prog_we_out(prog_we), .prog_idx_out(prog_idx),
    .prog_hz_out(prog_hz));
  // ==========
  // clock, event counting and hang guard
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  always @(negedge clk_in) begin
    cyc++;
    n_inb += (inb_ev === 1'b1);
    n_dtmf += (dtmf_ev === 1'b1);
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
  // ==========
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one-cycle load pulse, then let the outputs settle
  task automatic load_tx();
    tx_we = 1'b1;
    tick(1);
    tx_we = 1'b0;
    tick(2);
  endtask : load_tx
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // ==========
  // main sequence
  initial begin
    void'($urandom(32'hB9C9_B6D8));
    foreach (tbl[i]) tbl[i] = ibts_pkg::DEF_TABLE[i];
    tick(6);
    nrst_in = 1'b1;
    tick(1);
    check("status", status, 16'h0000);
    check("tone_on", tone_on, 1'b0);
    sel_en = 1'b1;
    // every default code, slightly off frequency, then tone ends
    for (int c = 0; c < 16; c++) begin
      n0 = n_inb;
      cand_hz = 12'(tbl[c] - 9 + int'($urandom % 19));
      cand_v = 1'b1;
      tick(3);
      check("sel_status", status, {1'b1, 4'(c), 11'h000});
      check("repeat", rep_seen, c == 14);
      cand_v = 1'b0;
      cand_hz = ~cand_hz;
      tick(3);
      check("cleared", status, 16'h0000);
      check("inb_events", n_inb - n0, 2);
    end
    // reprogram: duplicate entry, both range ends, one refused write
    host.write_entry(4'h3, 12'(tbl[1]));
    host.write_entry(4'h5, 12'hBB8);
    host.write_entry(4'h6, 12'h120);
    check("prog_err", prog_err, 1'b0);
    host.write_entry(4'h7, 12'h11F);
    check("prog_err", prog_err, 1'b1);
    // reference table follows the accepted writes only
    tbl[3] = tbl[1];
    tbl[5] = 3000;
    tbl[6] = 288;
    n0 = n_inb;
    for (int k = 0; k < 4; k++) begin
      cand_hz = 12'(hz_l[k]);
      cand_v = 1'b1;
      tick(3);
      check("prog_status", status, {1'b1, 4'(cd_l[k]), 11'h000});
    end
    cand_v = 1'b0;
    tick(3);
    check("change_events", n_inb - n0, 5);
    // dtmf with both detectors on
    dtmf_en = 1'b1;
    for (int c = 0; c < 16; c++) begin
      n0 = n_dtmf;
      dcode = 4'(c);
      dtmf_v = 1'b1;
      tick(3);
      check("dtmf_status", status, {1'b0, 4'(c), 1'b1, 10'h000});
      dtmf_v = 1'b0;
      dcode = ~dcode;
      tick(3);
      check("dtmf_events", n_dtmf - n0, 2);
    end
    // transmit every dtmf code, rotating through plain, twist and single modes, each followed by a selcall
    voice_req = 1'b1;
    for (int c = 0; c < 16; c++) begin
      m = c % 3;
      level = 4'($urandom);
      tx_word = {8'h00, 1'b1, 1'b0, m == 1, m == 2, 4'(c)};
      e_b = ibts_pkg::DTMF_COL[col_of[c]];
      e_a = (m == 2 && c > 7) ? e_b : ibts_pkg::DTMF_ROW[row_of[c]];
      load_tx();
      check("voice_en", voice_en, 1'b0);
      check("level", lvl_a, level);
      check("level_b", lvl_b, m == 2 ? 4'h0 : level);
      check("tone_on", tone_on, 1'b1);
      check("atten", atten, m == 1 ? 20 : 0);
      check("hz_a", hz_a, e_a);
      check("hz_b", hz_b, m == 2 ? 12'h000 : e_b);
      d = host.next_digit(4'(c / 2), prev);
      prev = 4'(c / 2);
      tx_word = {1'b1, d, 3'b000, 1'b1, 3'b000, 4'(c)};
      load_tx();
      check("sel_hz", hz_a, tbl[d]);
    end
    tx_word = 16'h0000;
    load_tx();
    check("voice_back", voice_en, 1'b1);
    conclude();
  end
endmodule : ibts_top_tb
`default_nettype wire
